// [cma_alu.sv]
// combinational arithmetic unit for add, subtract, carry forms and decimal adjust
// assumes operands arrive already selected by the executor
`timescale 1ns/10ps
module cma_alu import cma_pkg::*; (
   cma_alu_if.alu a_if
);
   logic [16:0] sum;
   logic [15:0] bb;
   logic cin;
   logic sub;
   logic [7:0] adj;
   logic fix_c;
   // result and flags
   always_comb begin
      sub = 1'b0;
      cin = 1'b0;
      bb = a_if.b;
      adj = 8'h00;
      fix_c = a_if.flags_in[CMA_FC];
      a_if.legal = 1'b1;
      case (a_if.op)
         CMA_OP_SUB, CMA_OP_MINUS_ONE, CMA_OP_SMALL_SUB: sub = 1'b1;
         CMA_OP_ADDC: cin = a_if.flags_in[CMA_FC];
         CMA_OP_SUBC: begin
            sub = 1'b1;
            cin = a_if.flags_in[CMA_FC];
         end
         default: sub = 1'b0;
      endcase
      // carry forms, inc/dec and decimal adjust are byte only
      if ((a_if.op == CMA_OP_ADDC || a_if.op == CMA_OP_SUBC || a_if.op == CMA_OP_INC ||
           a_if.op == CMA_OP_MINUS_ONE || a_if.op == CMA_OP_DFIX) && a_if.word)
         a_if.legal = 1'b0;
      if ((a_if.op == CMA_OP_ADDS || a_if.op == CMA_OP_SMALL_SUB) &&
          !(a_if.b == CMA_INC_B || a_if.b == CMA_INC_W))
         a_if.legal = 1'b0;
      if (a_if.op == CMA_OP_DFIX) begin
         if (a_if.a[3:0] > 4'h9 || a_if.flags_in[CMA_FV]) adj[3:0] = 4'h6;
         if (a_if.a[7:0] > 8'h99 || a_if.flags_in[CMA_FC]) begin
            adj[7:4] = 4'h6;
            fix_c = 1'b1;
         end
         bb = {8'h00, adj};
      end
      if (sub) sum = {1'b0, a_if.a} - {1'b0, bb} - {16'h0000, cin};
      else sum = {1'b0, a_if.a} + {1'b0, bb} + {16'h0000, cin};
      a_if.res = a_if.word ? sum[15:0] : {8'h00, sum[7:0]};
      a_if.flags_out = a_if.flags_in;
      if (a_if.op != CMA_OP_ADDS && a_if.op != CMA_OP_SMALL_SUB) begin
         if (a_if.word) begin
            a_if.flags_out[CMA_FN] = sum[15];
            a_if.flags_out[CMA_FZ] = (sum[15:0] == 16'h0000);
            a_if.flags_out[CMA_FV] = (a_if.a[15] ^ sum[15]) & ~(a_if.a[15] ^ bb[15] ^ sub);
            a_if.flags_out[CMA_FC] = sum[16];
         end else begin
            a_if.flags_out[CMA_FN] = sum[7];
            // carry forms only keep zero clear, never set it
            if (a_if.op == CMA_OP_ADDC || a_if.op == CMA_OP_SUBC)
               a_if.flags_out[CMA_FZ] = a_if.flags_in[CMA_FZ] & (sum[7:0] == 8'h00);
            else
               a_if.flags_out[CMA_FZ] = (sum[7:0] == 8'h00);
            a_if.flags_out[CMA_FV] = (a_if.a[7] ^ sum[7]) & ~(a_if.a[7] ^ bb[7] ^ sub);
            if (a_if.op == CMA_OP_DFIX) a_if.flags_out[CMA_FC] = fix_c;
            else if (a_if.op != CMA_OP_INC && a_if.op != CMA_OP_MINUS_ONE)
               a_if.flags_out[CMA_FC] = sum[8] ^ a_if.a[8] ^ bb[8];
         end
      end
   end
endmodule : cma_alu

// [cma_alu_if.sv]
// interface between the executor and its arithmetic unit
// assumes both ends share the core clock
`timescale 1ns/10ps
interface cma_alu_if;
   import cma_pkg::*;
   cma_op_t op;
   logic word;
   logic [15:0] a;
   logic [15:0] b;
   logic [3:0] flags_in;
   logic [15:0] res;
   logic [3:0] flags_out;
   logic legal;
   modport exec (output op, word, a, b, flags_in, input res, flags_out, legal);
   modport alu (input op, word, a, b, flags_in, output res, flags_out, legal);
endinterface : cma_alu_if

// [cma_exec.sv]
// execution unit for transfer and first-group arithmetic instructions
// assumes decoded requests arrive as fields and memory answers with mem_ack
// Functional notes
// - transfer_op copies register-register, register-memory, or immediate into register
// - transfer_op takes all listed modes with byte or word size, except eight-bit absolute, which is byte only
// - eight-bit absolute address only with byte size
// - stack_load_op reads a word then advances the stack pointer
// - stack_store_op decrements the stack pointer then writes a word
// - sum_op and difference_op on registers, byte or word; sum_op takes immediate
// - no immediate form of difference_op
// - word sum and difference only register to register
// - carry add and borrow subtract are byte only, using carry flag
// - increment and decrement one on a byte register
// - word add or subtract of 1 or 2 only; the code also takes these at byte size
// - decimal adjust a byte after addition
// - flag register holds negative, zero, overflow and carry
// - eight-bit absolute address has upper byte all ones
// - post-increment adds 1 for byte, 2 for word after access
// - pre-decrement subtracts 1 or 2 before access and keeps it
// - stack ops share encodings with word stack-pointer transfers
`timescale 1ns/10ps
module cma_exec import cma_pkg::*; #(
   parameter int NREG = CMA_NREG
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic req_valid,
   input wire cma_op_t req_op,
   input wire logic req_word,
   input wire logic req_to_mem,
   input wire cma_am_t req_mode,
   input wire logic [2:0] req_rd,
   input wire logic [2:0] req_rs,
   input wire logic [15:0] req_imm,
   output logic req_ready,
   output logic req_illegal,
   output logic mem_req,
   output logic mem_we,
   output logic [15:0] mem_addr,
   output logic [7:0] mem_wdata,
   input wire logic [7:0] mem_rdata,
   input wire logic mem_ack,
   output logic [3:0] flags,
   output logic [15:0] sp_value
);
   // register fields are three bits wide, so only eight registers can be served
   if (NREG != CMA_NREG) begin : g_bad_nreg
      $error("cma_exec serves exactly eight registers");
   end
   typedef enum {CMA_IDLE, CMA_MEM_HI, CMA_MEM_LO} cma_state_t;
   cma_state_t state;
   logic [15:0] regs [NREG];
   cma_alu_if alu_bus ();
   cma_alu u_alu (.a_if(alu_bus));
   cma_op_t op;
   logic word;
   logic to_mem;
   cma_am_t mode;
   logic [2:0] rd;
   logic [2:0] rs;
   logic [15:0] ea;
   logic [15:0] step;
   logic [15:0] base;
   logic [7:0] hi_byte;
   logic legal;
   logic is_mem;
   logic [2:0] areg;
   // request fields captured when a memory transfer is taken
   logic cur_word;
   logic [2:0] cur_rd;
   logic [15:0] cur_data;
   logic post_en;
   logic [2:0] post_reg;
   logic [15:0] post_val;
   logic [15:0] mv_src;
   logic [15:0] mem_word;
   // stack ops become word transfers through the stack pointer
   always_comb begin
      op = req_op;
      word = req_word;
      to_mem = req_to_mem;
      mode = req_mode;
      rd = req_rd;
      rs = req_rs;
      if (req_op == CMA_OP_PUSH) begin
         op = CMA_OP_MOVE;
         word = 1'b1;
         to_mem = 1'b1;
         mode = CMA_AM_PREDEC;
         rd = CMA_SP;
      end else if (req_op == CMA_OP_POP) begin
         op = CMA_OP_MOVE;
         word = 1'b1;
         to_mem = 1'b0;
         mode = CMA_AM_POSTINC;
         rs = CMA_SP;
      end
   end
   assign areg = to_mem ? rd : rs;
   assign base = regs[areg];
   assign step = word ? CMA_INC_W : CMA_INC_B;
   assign is_mem = (op == CMA_OP_MOVE) && !(mode == CMA_AM_REG || mode == CMA_AM_IMM);
   // flag sources for register moves and for finished memory transfers
   assign mv_src = (mode == CMA_AM_IMM) ? req_imm : regs[rs];
   assign mem_word = mem_we ? cur_data : {hi_byte, mem_rdata};
   // effective address per mode
   always_comb begin
      case (mode)
         CMA_AM_DISP: ea = base + req_imm;
         CMA_AM_ABS8: ea = {CMA_ABS8_HI, req_imm[7:0]};
         CMA_AM_ABS16: ea = req_imm;
         CMA_AM_PREDEC: ea = base - step;
         default: ea = base;
      endcase
      if (word) ea[0] = 1'b0;
   end
   // arithmetic operand selection
   always_comb begin
      alu_bus.op = op;
      alu_bus.word = word;
      alu_bus.flags_in = flags;
      alu_bus.a = word ? regs[rd] : {8'h00, regs[rd][7:0]};
      alu_bus.b = (mode == CMA_AM_IMM) ? req_imm : (word ? regs[rs] : {8'h00, regs[rs][7:0]});
      if (op == CMA_OP_INC || op == CMA_OP_MINUS_ONE) alu_bus.b = CMA_INC_B;
      if (op == CMA_OP_ADDS || op == CMA_OP_SMALL_SUB) alu_bus.b = req_imm;
      if (op == CMA_OP_DFIX) alu_bus.b = 16'h0000;
   end
   // addressing and size restrictions
   always_comb begin
      legal = alu_bus.legal;
      if (op == CMA_OP_MOVE && mode == CMA_AM_ABS8 && word) legal = 1'b0;
      if (op == CMA_OP_MOVE && mode == CMA_AM_IMM && to_mem) legal = 1'b0;
      if (op == CMA_OP_SUB && mode == CMA_AM_IMM) legal = 1'b0;
      if ((op == CMA_OP_ADD || op == CMA_OP_SUB) && word && mode != CMA_AM_REG)
         legal = 1'b0;
      if (op != CMA_OP_MOVE && !(mode == CMA_AM_REG || mode == CMA_AM_IMM)) legal = 1'b0;
   end
   // sequencing and memory bus; fields are captured when taken so the
   // requester may move on while the transfer runs
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state <= CMA_IDLE;
         req_ready <= 1'b1;
         req_illegal <= 1'b0;
         mem_req <= 1'b0;
         mem_we <= 1'b0;
         mem_addr <= 16'h0000;
         mem_wdata <= 8'h00;
         hi_byte <= 8'h00;
         cur_word <= 1'b0;
         cur_rd <= 3'h0;
         cur_data <= 16'h0000;
         post_en <= 1'b0;
         post_reg <= 3'h0;
         post_val <= 16'h0000;
      end else begin
         req_illegal <= 1'b0;
         case (state)
            CMA_IDLE: if (req_valid) begin
               if (!legal) req_illegal <= 1'b1;
               else if (is_mem) begin
                  mem_req <= 1'b1;
                  mem_we <= to_mem;
                  mem_addr <= ea;
                  mem_wdata <= word ? regs[rs][15:8] : regs[rs][7:0];
                  req_ready <= 1'b0;
                  cur_word <= word;
                  cur_rd <= rd;
                  cur_data <= regs[rs]; // store data taken before any address update
                  // loaded register wins over its own post-increment
                  post_en <= (mode == CMA_AM_POSTINC) && !(areg == rd && !to_mem);
                  post_reg <= areg;
                  post_val <= base + step;
                  state <= word ? CMA_MEM_HI : CMA_MEM_LO;
               end
            end
            CMA_MEM_HI: if (mem_ack) begin
               hi_byte <= mem_rdata;
               mem_addr <= mem_addr + CMA_INC_B;
               mem_wdata <= cur_data[7:0];
               state <= CMA_MEM_LO;
            end
            CMA_MEM_LO: if (mem_ack) begin
               mem_req <= 1'b0;
               mem_we <= 1'b0;
               req_ready <= 1'b1;
               state <= CMA_IDLE;
            end
            default: state <= CMA_IDLE;
         endcase
      end
   end
   // register file: moves, results, loads and address register updates
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < NREG; i++) regs[i] <= 16'h0000;
      end else if (state == CMA_IDLE && req_valid && legal) begin
         if (is_mem) begin
            if (mode == CMA_AM_PREDEC) regs[areg] <= ea;
         end else if (op == CMA_OP_MOVE) begin
            if (mode == CMA_AM_IMM)
               regs[rd] <= word ? req_imm : {regs[rd][15:8], req_imm[7:0]};
            else
               regs[rd] <= word ? regs[rs] : {regs[rd][15:8], regs[rs][7:0]};
         end else begin
            regs[rd] <= word ? alu_bus.res : {regs[rd][15:8], alu_bus.res[7:0]};
         end
      end else if (state == CMA_MEM_LO && mem_ack) begin
         // post-increment after the access
         if (post_en) regs[post_reg] <= post_val;
         if (!mem_we) begin
            regs[cur_rd] <= cur_word ? {hi_byte, mem_rdata} : {regs[cur_rd][15:8], mem_rdata};
         end
      end
   end
   // condition flags: moves set N and Z, clear V, keep C
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         flags <= CMA_FLAGS_RESET;
      end else if (state == CMA_IDLE && req_valid && legal && !is_mem) begin
         if (op == CMA_OP_MOVE) begin
            flags[CMA_FN] <= word ? mv_src[15] : mv_src[7];
            flags[CMA_FZ] <= word ? (mv_src == 16'h0000) : (mv_src[7:0] == 8'h00);
            flags[CMA_FV] <= 1'b0;
         end else begin
            flags <= alu_bus.flags_out;
         end
      end else if (state == CMA_MEM_LO && mem_ack) begin
         flags[CMA_FN] <= cur_word ? mem_word[15] : mem_word[7];
         flags[CMA_FZ] <= cur_word ? (mem_word == 16'h0000) : (mem_word[7:0] == 8'h00);
         flags[CMA_FV] <= 1'b0;
      end
   end
   // stack pointer mirror, one cycle behind register seven
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sp_value <= CMA_SP_RESET;
      end else begin
         sp_value <= regs[CMA_SP_IDX];
      end
   end
endmodule : cma_exec

// [cma_exec_properties.sv]
// assertions on the executor's request, memory and stack ports
// assumes binding to cma_exec, one clock and an active-low reset
`timescale 1ns/10ps
module cma_exec_properties import cma_pkg::*; (
   input wire logic clk,
   input wire logic nrst,
   input wire logic req_valid,
   input wire logic req_ready,
   input wire cma_op_t req_op,
   input wire logic req_word,
   input wire cma_am_t req_mode,
   input wire logic [15:0] req_imm,
   input wire logic req_illegal,
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic [15:0] mem_addr,
   input wire logic [15:0] sp_value
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   logic tk;
   logic [7:0] imm_lo;
   // request taken at this edge, low immediate byte
   assign tk = req_valid && req_ready;
   assign imm_lo = req_imm[7:0];
   sequence refused;
      req_illegal && !mem_req;
   endsequence
   sequence push_first;
      mem_req && mem_we && !mem_addr[0];
   endsequence
   sequence push_sp;
      sp_value == {mem_addr[15:1], 1'b0};
   endsequence
   abs8_word_a: assert property (tk && req_op == CMA_OP_MOVE && req_mode == CMA_AM_ABS8
      && req_word |=> refused) else $error("word move with short address taken");
   sub_imm_a: assert property (tk && req_op == CMA_OP_SUB && req_mode == CMA_AM_IMM
      |=> refused) else $error("immediate subtract taken");
   word_arith_a: assert property (tk && req_op inside {CMA_OP_ADD, CMA_OP_SUB} && req_word
      && req_mode != CMA_AM_REG |=> refused) else $error("word arithmetic off registers");
   carry_word_a: assert property (tk && req_op inside {CMA_OP_ADDC, CMA_OP_SUBC}
      && req_word |=> refused) else $error("word carry form taken");
   incdec_word_a: assert property (tk && req_op inside {CMA_OP_INC, CMA_OP_MINUS_ONE}
      && req_word |=> refused) else $error("word step by one taken");
   small_const_a: assert property (tk && req_op inside {CMA_OP_ADDS, CMA_OP_SMALL_SUB}
      && !(req_imm inside {16'h0001, 16'h0002}) |=> refused) else $error("bad small constant");
   abs8_high_a: assert property (tk && req_op == CMA_OP_MOVE && req_mode == CMA_AM_ABS8
      && !req_word |=> mem_req && mem_addr == {CMA_ABS8_HI, $past(imm_lo)})
      else $error("short address not in top page");
   push_order_a: assert property (tk && req_op == CMA_OP_PUSH
      |=> push_first ##1 push_sp) else $error("push not decrement then write");
   pop_read_a: assert property (tk && req_op == CMA_OP_POP
      |=> mem_req && !mem_we && !req_ready) else $error("pop not a blocking read");
endmodule : cma_exec_properties
bind cma_exec cma_exec_properties u_props (.clk(clk), .nrst(nrst), .req_valid(req_valid),
   .req_ready(req_ready), .req_op(req_op), .req_word(req_word), .req_mode(req_mode),
   .req_imm(req_imm), .req_illegal(req_illegal), .mem_req(mem_req), .mem_we(mem_we),
   .mem_addr(mem_addr), .sp_value(sp_value));

// [cma_mem_model.sv]
// memory partner answering the byte-wide data bus of the executor
// assumes each byte request stands until acked; one ack pulse per byte
`timescale 1ns/10ps
module cma_mem_model (
   input wire logic clk,
   input wire logic nrst,
   input wire logic slow,
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic [15:0] mem_addr,
   input wire logic [7:0] mem_wdata,
   output logic [7:0] mem_rdata,
   output logic mem_ack
);
   logic [7:0] mem [0:65535];
   logic [1:0] wait_cnt;
   // ack each byte after an optional wait; idle read data keeps toggling
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         mem_ack <= 1'b0;
         mem_rdata <= 8'h00;
         wait_cnt <= 2'h0;
      end else begin
         mem_ack <= 1'b0;
         mem_rdata <= ~mem_rdata;
         if (mem_req && !mem_ack) begin
            wait_cnt <= wait_cnt + 2'h1;
            if (!slow || wait_cnt == 2'h3) begin
               mem_ack <= 1'b1;
               wait_cnt <= 2'h0;
               if (mem_we) mem[mem_addr] <= mem_wdata;
               else mem_rdata <= mem[mem_addr];
            end
         end
      end
   end
endmodule : cma_mem_model

// [cma_pkg.sv]
// package for the move/arithmetic execution block
// assumes one 20 MHz clock domain and a byte-wide memory data bus
package cma_pkg;
   localparam int CMA_NREG = 8;
   localparam int CMA_SP_IDX = 7;
   localparam logic [2:0] CMA_SP = 3'h7;
   localparam logic [7:0] CMA_ABS8_HI = 8'hFF;
   localparam logic [15:0] CMA_INC_B = 16'h0001;
   localparam logic [15:0] CMA_INC_W = 16'h0002;
   localparam logic [15:0] CMA_SP_RESET = 16'h0000;
   localparam logic [3:0] CMA_FLAGS_RESET = 4'h0;
   localparam int CMA_FN = 3;
   localparam int CMA_FZ = 2;
   localparam int CMA_FV = 1;
   localparam int CMA_FC = 0;
   localparam int CMA_CLK_MHZ = 20;
   // operation codes
   typedef enum logic [3:0] {
      CMA_OP_MOVE, CMA_OP_PUSH, CMA_OP_POP, CMA_OP_ADD, CMA_OP_SUB, CMA_OP_ADDC,
      CMA_OP_SUBC, CMA_OP_INC, CMA_OP_MINUS_ONE, CMA_OP_ADDS, CMA_OP_SMALL_SUB, CMA_OP_DFIX
   } cma_op_t;
   // addressing modes
   typedef enum logic [2:0] {
      CMA_AM_REG, CMA_AM_IND, CMA_AM_DISP, CMA_AM_ABS8, CMA_AM_ABS16, CMA_AM_IMM,
      CMA_AM_POSTINC, CMA_AM_PREDEC
   } cma_am_t;
endpackage : cma_pkg

// [tb_cpu_move_arith_exec.sv]
// self-checking bench for the move and arithmetic executor
// assumes the memory partner model and the bound checker
`timescale 1ns/10ps
module tb_cpu_move_arith_exec;
   import cma_pkg::*;
   logic clk = 1'b0, nrst = 1'b0, req_valid = 1'b0, req_word = 1'b0, req_to_mem = 1'b0;
   logic slow = 1'b0, ill, req_ready, req_illegal, mem_req, mem_we, mem_ack;
   cma_op_t req_op = CMA_OP_MOVE;
   cma_am_t req_mode = CMA_AM_REG;
   logic [2:0] req_rd = 3'h0, req_rs = 3'h0;
   logic [15:0] req_imm = 16'h0000, mem_addr, sp_value;
   logic [7:0] mem_wdata, mem_rdata;
   logic [3:0] flags;
   int n_errors = 0, checked = 0;
   cma_exec dut (.clk(clk), .nrst(nrst), .req_valid(req_valid), .req_op(req_op),
      .req_word(req_word), .req_to_mem(req_to_mem), .req_mode(req_mode), .req_rd(req_rd),
      .req_rs(req_rs), .req_imm(req_imm), .req_ready(req_ready), .req_illegal(req_illegal),
      .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
      .mem_rdata(mem_rdata), .mem_ack(mem_ack), .flags(flags), .sp_value(sp_value));
   cma_mem_model u_mem (.clk(clk), .nrst(nrst), .slow(slow), .mem_req(mem_req),
      .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
      .mem_ack(mem_ack));
   // clock generator
   initial begin
      forever #25 clk = ~clk;
   end
   task automatic wrap_up;
      if (n_errors == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : wrap_up
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // offer one request, capture the refusal pulse, wait for idle
   task automatic run(input cma_op_t op, input logic w, input logic tm, input cma_am_t md,
      input logic [2:0] rd, input logic [2:0] rs, input logic [15:0] imm);
      int i;
      @(negedge clk);
      req_op = op;
      req_word = w;
      req_to_mem = tm;
      req_mode = md;
      req_rd = rd;
      req_rs = rs;
      req_imm = imm;
      req_valid = 1'b1;
      @(negedge clk);
      ill = req_illegal;
      req_valid = 1'b0;
      for (i = 0; i < 60 && req_ready !== 1'b1; i++) @(negedge clk);
      if (i == 60) begin
         n_errors++;
         $display("mismatch %0t request never completed", $time);
         wrap_up();
      end
   endtask : run
   // store a register word at 0x0080 and compare memory
   task automatic st_chk(input logic [2:0] rs, input logic [15:0] exp);
      run(CMA_OP_MOVE, 1'b1, 1'b1, CMA_AM_ABS16, 3'h0, rs, 16'h0080);
      chk({u_mem.mem[16'h0080], u_mem.mem[16'h0081]}, exp);
   endtask : st_chk
   task automatic t_move;
      run(CMA_OP_MOVE, 1'b1, 1'b0, CMA_AM_IMM, 3'h1, 3'h0, 16'h1234);
      st_chk(3'h1, 16'h1234);
      run(CMA_OP_MOVE, 1'b0, 1'b1, CMA_AM_ABS8, 3'h0, 3'h1, 16'h0021);
      chk({8'h00, u_mem.mem[16'hFF21]}, 16'h0034);
      run(CMA_OP_MOVE, 1'b1, 1'b0, CMA_AM_IMM, 3'h6, 3'h0, 16'hFF21);
      run(CMA_OP_MOVE, 1'b0, 1'b0, CMA_AM_POSTINC, 3'h2, 3'h6, 16'h0000);
      st_chk(3'h2, 16'h0034);
      st_chk(3'h6, 16'hFF22);
      run(CMA_OP_MOVE, 1'b0, 1'b1, CMA_AM_PREDEC, 3'h6, 3'h1, 16'h0000);
      st_chk(3'h6, 16'hFF21);
      run(CMA_OP_MOVE, 1'b1, 1'b1, CMA_AM_DISP, 3'h6, 3'h1, 16'h0100);
      chk({u_mem.mem[16'h0020], u_mem.mem[16'h0021]}, 16'h1234);
   endtask : t_move
   task automatic t_stack;
      slow = 1'b1;
      run(CMA_OP_MOVE, 1'b1, 1'b0, CMA_AM_IMM, 3'h7, 3'h0, 16'h0010);
      run(CMA_OP_PUSH, 1'b1, 1'b1, CMA_AM_PREDEC, 3'h7, 3'h1, 16'h0000);
      chk(sp_value, 16'h000E);
      chk({u_mem.mem[16'h000E], u_mem.mem[16'h000F]}, 16'h1234);
      run(CMA_OP_POP, 1'b1, 1'b0, CMA_AM_POSTINC, 3'h3, 3'h7, 16'h0000);
      @(negedge clk); // sp_value trails register seven by one cycle
      chk(sp_value, 16'h0010);
      st_chk(3'h3, 16'h1234);
      run(CMA_OP_MOVE, 1'b1, 1'b1, CMA_AM_PREDEC, 3'h7, 3'h3, 16'h0000);
      chk(sp_value, 16'h000E);
      slow = 1'b0;
   endtask : t_stack
   task automatic t_arith;
      run(CMA_OP_MOVE, 1'b1, 1'b0, CMA_AM_IMM, 3'h4, 3'h0, 16'h0001);
      run(CMA_OP_ADD, 1'b0, 1'b0, CMA_AM_IMM, 3'h4, 3'h0, 16'h00FF);
      chk({12'h000, flags}, 16'h0005);
      run(CMA_OP_ADDC, 1'b0, 1'b0, CMA_AM_IMM, 3'h4, 3'h0, 16'h0000);
      st_chk(3'h4, 16'h0001);
      run(CMA_OP_INC, 1'b0, 1'b0, CMA_AM_REG, 3'h4, 3'h4, 16'h0000);
      run(CMA_OP_ADD, 1'b1, 1'b0, CMA_AM_REG, 3'h4, 3'h1, 16'h0000);
      st_chk(3'h4, 16'h1236);
      run(CMA_OP_ADDS, 1'b1, 1'b0, CMA_AM_IMM, 3'h4, 3'h4, 16'h0002);
      run(CMA_OP_SMALL_SUB, 1'b1, 1'b0, CMA_AM_IMM, 3'h4, 3'h4, 16'h0001);
      run(CMA_OP_SUB, 1'b1, 1'b0, CMA_AM_REG, 3'h4, 3'h1, 16'h0000);
      st_chk(3'h4, 16'h0003);
      run(CMA_OP_MOVE, 1'b1, 1'b0, CMA_AM_IMM, 3'h5, 3'h0, 16'h000A);
      run(CMA_OP_DFIX, 1'b0, 1'b0, CMA_AM_REG, 3'h5, 3'h5, 16'h0000);
      st_chk(3'h5, 16'h0010);
      run(CMA_OP_MINUS_ONE, 1'b0, 1'b0, CMA_AM_REG, 3'h5, 3'h5, 16'h0000);
      run(CMA_OP_SUBC, 1'b0, 1'b0, CMA_AM_IMM, 3'h5, 3'h0, 16'h0010);
      st_chk(3'h5, 16'h00FF);
   endtask : t_arith
   task automatic t_illegal;
      cma_op_t ops [6] = '{CMA_OP_SUB, CMA_OP_ADDC, CMA_OP_ADDS, CMA_OP_MOVE, CMA_OP_ADD,
         CMA_OP_INC};
      logic wds [6] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
      cma_am_t mds [6] = '{CMA_AM_IMM, CMA_AM_REG, CMA_AM_IMM, CMA_AM_ABS8, CMA_AM_IND,
         CMA_AM_REG};
      for (int k = 0; k < 6; k++) begin
         run(ops[k], wds[k], 1'b0, mds[k], 3'h4, 3'h1, 16'h0003);
         chk({15'h0000, ill}, 16'h0001);
      end
      st_chk(3'h4, 16'h0003);
   endtask : t_illegal
   // reset, then scenarios
   initial begin
      repeat (16) @(negedge clk);
      nrst = 1'b1;
      t_move();
      t_stack();
      t_arith();
      t_illegal();
      wrap_up();
   end
endmodule : tb_cpu_move_arith_exec
